// >>> rtl/alu_exec_pkg.sv
// constants, operation codes and carrier types for the execute slice
`default_nettype none
package alu_exec_pkg;
   // register offsets (byte addresses on the bus)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_INSTR = 8'h04;
   localparam logic [7:0] OFF_ACC = 8'h08;
   localparam logic [7:0] OFF_MEM = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_PC = 8'h14;
   localparam logic [7:0] OFF_STACK = 8'h18;
   // status field positions
   localparam int unsigned BIT_CARRY = 0;
   localparam int unsigned BIT_HALF = 1;
   localparam int unsigned BIT_ZERO = 2;
   localparam int unsigned BIT_EXCESS = 3;
   localparam int unsigned BIT_SLEEP = 4;
   localparam int unsigned BIT_EXPIRY = 5;
   localparam int unsigned BIT_IRQEN = 6;
   localparam int unsigned BIT_BUSY = 7;
   // instruction word fields: [23:16] op, [15:0] operand
   localparam int unsigned OP_LSB = 16;
   // reset values and constants
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [7:0] BCD_LIMIT = 8'h09;
   localparam logic [7:0] BCD_LOW_FIX = 8'h06;
   localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
   localparam logic [1:0] LONG_CYCLES = 2'h2;

   typedef enum logic [7:0] {
      OP_IDLE = 8'h00, OP_INVERT_MEM = 8'h01, OP_INVERT_ACC = 8'h02,
      OP_BCD_ADJUST = 8'h03, OP_DEC_MEM = 8'h04, OP_DEC_ACC = 8'h05,
      OP_INC_MEM = 8'h06, OP_INC_ACC = 8'h07, OP_SLEEP = 8'h08,
      OP_BRANCH = 8'h09, OP_COPY_M2A = 8'h0a, OP_COPY_I2A = 8'h0b,
      OP_COPY_A2M = 8'h0c, OP_OR_MEM2A = 8'h0d, OP_OR_IMM2A = 8'h0e,
      OP_OR_A2MEM = 8'h0f, OP_SUB_EXIT = 8'h10, OP_SUB_EXIT_VAL = 8'h11,
      OP_IRQ_EXIT = 8'h12, OP_ROT_L_MEM = 8'h13, OP_ROT_L_ACC = 8'h14,
      OP_ROT_LC_MEM = 8'h15, OP_ROT_LC_ACC = 8'h16, OP_ROT_R_MEM = 8'h17,
      OP_ROT_R_ACC = 8'h18, OP_ROT_RC_MEM = 8'h19, OP_ROT_RC_ACC = 8'h1a,
      OP_SUB_BORROW = 8'h1b, OP_WRITE_PCL = 8'h1c
   } op_t;

   typedef enum logic [1:0] {
      ST_FETCH = 2'b00, ST_DUMMY = 2'b01, ST_ASLEEP = 2'b11
   } phase_t;

   typedef struct packed {
      logic irq_en;
      logic expiry;
      logic sleep;
      logic excess;
      logic zero;
      logic half;
      logic carry;
   } flags_t;

   typedef struct packed {
      phase_t phase;
      logic [7:0] acc;
      logic [7:0] mem;
      flags_t flags;
      logic [15:0] pc;
      logic [15:0] stack;
      logic irq_pend;
      logic wdt_clr;
      logic rd_ok;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_addr;
   } state_t;
endpackage
`default_nettype wire

// >>> rtl/alu_exec.sv
// execute slice of an 8-bit accumulator core behind an ahb-lite slave
`default_nettype none
// Summary of operation
// [RULE1] invert memory byte, to memory or accumulator
// [RULE2] bcd low nibble add 6 if over 9
// [RULE3] bcd high nibble add 6 if over 9
// [RULE4] bcd result to memory, only carry changes
// [RULE5] decrement to memory or accumulator, zero only
// [RULE6] increment to memory or accumulator, zero only
// [RULE7] sleep stops execution, keeps all state
// [RULE8] sleep clears watchdog, sets sleep flag
// [RULE9] branch loads pc, takes two cycles
// [RULE10] copies change no flag
// [RULE11] idle only advances the pc
// [RULE12] or to accumulator or memory, zero only
// [RULE13] subroutine exit pops pc, no flags
// [RULE14] exit with value also loads accumulator
// [RULE15] interrupt exit pops pc, sets irq enable
// [RULE16] pending interrupt served before resuming main
// [RULE17] rotate left, bit 7 into bit 0
// [RULE18] rotate left via carry
// [RULE19] rotate right, bit 0 into bit 7
// [RULE20] rotate right via carry
// [RULE21] subtract with borrow updates four flags
// [RULE22] carry clear on negative, set otherwise
// [RULE23] writing pc low takes two cycles
// [RULE24] 8-bit data, zero flag from result
// [RULE25] other ops finish in one cycle; the three exits also take two cycles
module alu_exec #(
   parameter int unsigned DATA_W = 8,
   parameter logic [15:0] IRQ_VECTOR = 16'h0004
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic irq_req,
   output logic sleep_active,
   output logic watchdog_clear
);
   // [RULE24] only 8-bit data served
   if (DATA_W != 8) begin : g_width_check
      $error("alu_exec supports only 8-bit data");
   end

   alu_exec_pkg::state_t cur;
   alu_exec_pkg::state_t nxt;
   logic [2:0] irq_sync;
   logic take_wr;
   logic take_rd;
   logic [7:0] op;
   logic [7:0] imm;
   logic [15:0] addr_f;
   logic [8:0] dif;
   logic [4:0] dif_lo;
   logic [7:0] fix;
   logic [8:0] bcd;
   logic [7:0] res;
   logic long_op;

   // irq pin into the clock domain; three stages in a row, stage three feeds irq_pend
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_sync <= 3'h0;
      end else begin
         irq_sync <= {irq_sync[1:0], irq_req};
      end
   end

   assign take_wr = hsel && hready && htrans[1] && hwrite;
   assign take_rd = hsel && hready && htrans[1] && !hwrite;
   assign op = hwdata[alu_exec_pkg::OP_LSB +: 8];
   assign imm = hwdata[7:0];
   assign addr_f = hwdata[15:0];
   // subtract with borrow: acc - mem - ~carry
   assign dif = {1'b0, cur.acc} - {1'b0, cur.mem}
      - {8'h00, ~cur.flags.carry};
   assign dif_lo = {1'b0, cur.acc[3:0]} - {1'b0, cur.mem[3:0]}
      - {4'h0, ~cur.flags.carry};
   // bcd correction term
   always_comb begin
      fix = 8'h00;
      // [RULE2] low nibble fix
      if (cur.acc[3:0] > alu_exec_pkg::BCD_LIMIT[3:0] || cur.flags.half) begin
         fix = fix | alu_exec_pkg::BCD_LOW_FIX;
      end
      // [RULE3] high nibble fix
      if (cur.acc[7:4] > alu_exec_pkg::BCD_LIMIT[3:0] || cur.flags.carry) begin
         fix = fix | alu_exec_pkg::BCD_HIGH_FIX;
      end
   end
   assign bcd = {1'b0, cur.acc} + {1'b0, fix};

   // next-state logic: bus writes, instruction execution, readback
   always_comb begin
      nxt = cur;
      res = 8'h00;
      long_op = 1'b0;
      nxt.wdt_clr = 1'b0;
      nxt.rd_ok = 1'b0;
      nxt.wr_pend = take_wr;
      if (take_wr) begin
         nxt.wr_addr = haddr[7:0];
      end
      // level pending interrupt from the synchroniser's third stage
      nxt.irq_pend = irq_sync[2];
      if (cur.phase == alu_exec_pkg::ST_DUMMY) begin
         // [RULE16] pending interrupt taken before main program
         if (cur.irq_pend && cur.flags.irq_en) begin
            nxt.stack = cur.pc;
            nxt.pc = IRQ_VECTOR;
            nxt.flags.irq_en = 1'b0;
         end
         nxt.phase = alu_exec_pkg::ST_FETCH;
      end
      if (cur.wr_pend) begin
         case (cur.wr_addr)
            alu_exec_pkg::OFF_ACC: nxt.acc = hwdata[7:0];
            alu_exec_pkg::OFF_MEM: nxt.mem = hwdata[7:0];
            alu_exec_pkg::OFF_PC: nxt.pc = hwdata[15:0];
            alu_exec_pkg::OFF_STACK: nxt.stack = hwdata[15:0];
            alu_exec_pkg::OFF_STATUS: nxt.flags = hwdata[6:0];
            alu_exec_pkg::OFF_CTRL: begin
               // wake from sleep
               if (hwdata[0]) begin
                  nxt.phase = alu_exec_pkg::ST_FETCH;
               end
            end
            alu_exec_pkg::OFF_INSTR: begin
               // [RULE7] asleep or busy: instruction ignored
               if (cur.phase == alu_exec_pkg::ST_FETCH) begin
                  nxt.pc = cur.pc + 16'h0001;
                  case (op)
                     // [RULE11] idle only advances pc
                     alu_exec_pkg::OP_IDLE: res = 8'h00;
                     // [RULE1] invert to memory
                     alu_exec_pkg::OP_INVERT_MEM: begin
                        res = ~cur.mem;
                        nxt.mem = res;
                        nxt.flags.zero = (res == 8'h00);
                     end
                     // [RULE1] invert to accumulator
                     alu_exec_pkg::OP_INVERT_ACC: begin
                        res = ~cur.mem;
                        nxt.acc = res;
                        nxt.flags.zero = (res == 8'h00);
                     end
                     // [RULE4] adjusted value to memory, carry only
                     alu_exec_pkg::OP_BCD_ADJUST: begin
                        nxt.mem = bcd[7:0];
                        nxt.flags.carry = bcd[8] | cur.flags.carry;
                     end
                     // [RULE5] decrement
                     alu_exec_pkg::OP_DEC_MEM, alu_exec_pkg::OP_DEC_ACC: begin
                        res = cur.mem - 8'h01;
                        if (op == alu_exec_pkg::OP_DEC_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                        nxt.flags.zero = (res == 8'h00);
                     end
                     // [RULE6] increment
                     alu_exec_pkg::OP_INC_MEM, alu_exec_pkg::OP_INC_ACC: begin
                        res = cur.mem + 8'h01;
                        if (op == alu_exec_pkg::OP_INC_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                        nxt.flags.zero = (res == 8'h00);
                     end
                     // [RULE8] sleep entry clears watchdog
                     alu_exec_pkg::OP_SLEEP: begin
                        nxt.flags.sleep = 1'b1;
                        nxt.flags.expiry = 1'b0;
                        nxt.wdt_clr = 1'b1;
                        nxt.phase = alu_exec_pkg::ST_ASLEEP;
                     end
                     // [RULE9] branch loads address field
                     alu_exec_pkg::OP_BRANCH: begin
                        nxt.pc = addr_f;
                        long_op = 1'b1;
                     end
                     // [RULE10] copies leave flags alone
                     alu_exec_pkg::OP_COPY_M2A: nxt.acc = cur.mem;
                     alu_exec_pkg::OP_COPY_I2A: nxt.acc = imm;
                     alu_exec_pkg::OP_COPY_A2M: nxt.mem = cur.acc;
                     // [RULE12] or variants
                     alu_exec_pkg::OP_OR_MEM2A, alu_exec_pkg::OP_OR_IMM2A,
                     alu_exec_pkg::OP_OR_A2MEM: begin
                        res = cur.acc | ((op == alu_exec_pkg::OP_OR_IMM2A)
                           ? imm : cur.mem);
                        if (op == alu_exec_pkg::OP_OR_A2MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                        nxt.flags.zero = (res == 8'h00);
                     end
                     // [RULE13] pop pc
                     alu_exec_pkg::OP_SUB_EXIT: begin
                        nxt.pc = cur.stack;
                        long_op = 1'b1;
                     end
                     // [RULE14] pop pc and load value
                     alu_exec_pkg::OP_SUB_EXIT_VAL: begin
                        nxt.pc = cur.stack;
                        nxt.acc = imm;
                        long_op = 1'b1;
                     end
                     // [RULE15] pop pc, re-enable interrupts
                     alu_exec_pkg::OP_IRQ_EXIT: begin
                        nxt.pc = cur.stack;
                        nxt.flags.irq_en = 1'b1;
                        long_op = 1'b1;
                     end
                     // [RULE17] rotate left
                     alu_exec_pkg::OP_ROT_L_MEM, alu_exec_pkg::OP_ROT_L_ACC:
                     begin
                        res = {cur.mem[6:0], cur.mem[7]};
                        if (op == alu_exec_pkg::OP_ROT_L_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                     end
                     // [RULE18] rotate left via carry
                     alu_exec_pkg::OP_ROT_LC_MEM, alu_exec_pkg::OP_ROT_LC_ACC:
                     begin
                        res = {cur.mem[6:0], cur.flags.carry};
                        nxt.flags.carry = cur.mem[7];
                        if (op == alu_exec_pkg::OP_ROT_LC_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                     end
                     // [RULE19] rotate right
                     alu_exec_pkg::OP_ROT_R_MEM, alu_exec_pkg::OP_ROT_R_ACC:
                     begin
                        res = {cur.mem[0], cur.mem[7:1]};
                        if (op == alu_exec_pkg::OP_ROT_R_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                     end
                     // [RULE20] rotate right via carry
                     alu_exec_pkg::OP_ROT_RC_MEM, alu_exec_pkg::OP_ROT_RC_ACC:
                     begin
                        res = {cur.flags.carry, cur.mem[7:1]};
                        nxt.flags.carry = cur.mem[0];
                        if (op == alu_exec_pkg::OP_ROT_RC_MEM) begin
                           nxt.mem = res;
                        end else begin
                           nxt.acc = res;
                        end
                     end
                     // [RULE21] subtract with borrow, four flags
                     alu_exec_pkg::OP_SUB_BORROW: begin
                        res = dif[7:0];
                        nxt.acc = res;
                        nxt.flags.zero = (res == 8'h00);
                        // [RULE22] carry set when not negative
                        nxt.flags.carry = ~dif[8];
                        nxt.flags.half = ~dif_lo[4];
                        nxt.flags.excess = (cur.acc[7] != cur.mem[7])
                           && (res[7] != cur.acc[7]);
                     end
                     // [RULE23] pc low write costs two cycles
                     alu_exec_pkg::OP_WRITE_PCL: begin
                        nxt.pc = {cur.pc[15:8], imm};
                        long_op = 1'b1;
                     end
                     default: res = 8'h00;
                  endcase
                  // [RULE25] single cycle unless pc is loaded (branch, the three exits, pc low write)
                  if (long_op) begin
                     nxt.phase = alu_exec_pkg::ST_DUMMY;
                  end
               end
            end
            default: res = 8'h00;
         endcase
      end
      // read data launched in the data phase
      if (take_rd) begin
         nxt.rd_ok = 1'b1;
         case (haddr[7:0])
            alu_exec_pkg::OFF_ACC: nxt.rdata = {24'h0, cur.acc};
            alu_exec_pkg::OFF_MEM: nxt.rdata = {24'h0, cur.mem};
            alu_exec_pkg::OFF_PC: nxt.rdata = {16'h0, cur.pc};
            alu_exec_pkg::OFF_STACK: nxt.rdata = {16'h0, cur.stack};
            alu_exec_pkg::OFF_STATUS: begin
               nxt.rdata = {24'h0, cur.phase != alu_exec_pkg::ST_FETCH,
                  cur.flags};
            end
            default: nxt.rdata = 32'h0;
         endcase
      end
   end

   // single state register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign hrdata = cur.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign sleep_active = (cur.phase == alu_exec_pkg::ST_ASLEEP);
   assign watchdog_clear = cur.wdt_clr;

   property p_sleep_flags;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(sleep_active) |-> cur.flags.sleep && !cur.flags.expiry
         && watchdog_clear;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) // [RULE8]
      else $error("sleep entry flags wrong");
   property p_dummy_one;
      @(posedge ref_clk) disable iff (!nrst)
      cur.phase == alu_exec_pkg::ST_DUMMY |=>
         cur.phase != alu_exec_pkg::ST_DUMMY;
   endproperty
   a_dummy_one: assert property (p_dummy_one) // [RULE9]
      else $error("dummy cycle longer than one");
   property p_sleep_hold;
      @(posedge ref_clk) disable iff (!nrst)
      sleep_active && !cur.wr_pend |=> $stable(cur.acc) && $stable(cur.pc);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // [RULE7]
      else $error("state changed while asleep");
   sequence s_exec(logic [7:0] code);
      cur.wr_pend && cur.wr_addr == alu_exec_pkg::OFF_INSTR
         && cur.phase == alu_exec_pkg::ST_FETCH && op == code;
   endsequence
   property p_inc;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_INC_ACC) |=>
         cur.acc == $past(cur.mem) + 8'h01 && $stable(cur.mem);
   endproperty
   a_inc: assert property (p_inc) // [RULE6]
      else $error("increment result wrong");
   property p_dec;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_DEC_MEM) |=>
         cur.mem == $past(cur.mem) - 8'h01
         && cur.flags.carry == $past(cur.flags.carry);
   endproperty
   a_dec: assert property (p_dec) // [RULE5]
      else $error("decrement result wrong");
   property p_branch;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_BRANCH) |=>
         cur.pc == $past(addr_f) && cur.phase == alu_exec_pkg::ST_DUMMY;
   endproperty
   a_branch: assert property (p_branch) // [RULE9]
      else $error("branch target or timing wrong");

   property p_irq_exit;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_IRQ_EXIT) |=>
         cur.flags.irq_en && cur.pc == $past(cur.stack);
   endproperty
   a_irq_exit: assert property (p_irq_exit) // [RULE15]
      else $error("interrupt exit wrong");

   property p_sub_carry;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_SUB_BORROW) |=>
         cur.flags.carry == ({1'b0, $past(cur.acc)} >= {1'b0, $past(cur.mem)}
         + {8'h00, ~$past(cur.flags.carry)});
   endproperty
   a_sub_carry: assert property (p_sub_carry) // [RULE22]
      else $error("subtract carry wrong");

   property p_copy;
      @(posedge ref_clk) disable iff (!nrst)
      s_exec(alu_exec_pkg::OP_COPY_A2M) |=>
         cur.mem == $past(cur.acc) && $stable(cur.flags);
   endproperty
   a_copy: assert property (p_copy) // [RULE10]
      else $error("copy changed flags");
endmodule
`default_nettype wire

// >>> testbench/alu_exec_test.sv
// self-checking bench for the execute slice over its ahb-lite port
`default_nettype none
module alu_exec_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] IRQ_VEC = 16'h0040;
   logic ref_clk, nrst, hsel, hwrite, irq_req;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, sleep_active, watchdog_clear;
   wire logic hready;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int wdc_cnt = 0;
   int n;
   logic [19:0] e;
   logic [7:0] va [4] = '{8'h00, 8'h7f, 8'h80, 8'h3c};
   logic [7:0] vm [4] = '{8'h01, 8'hff, 8'h01, 8'hc3};
   logic [3:0] vf [4] = '{4'h0, 4'h1, 4'h3, 4'h6};

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   alu_exec #(.IRQ_VECTOR(IRQ_VEC)) u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq_req(irq_req), .sleep_active(sleep_active),
      .watchdog_clear(watchdog_clear)
   );

   // free-running clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watchdog clear pulses and hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (watchdog_clear === 1'b1) wdc_cnt <= wdc_cnt + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("BAD t=%0t run did not finish", $time);
         test_done();
      end
   end

   task automatic chk(input logic [15:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // address phase held until ready is sampled high
   task automatic addr_ph(input logic [7:0] a, input logic w);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_ph(a, 1'b1);
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_ph(a, 1'b0);
      do @(posedge ref_clk); while (hready !== 1'b1);
      d = hrdata;
      chk({15'h0000, hresp}, 16'h0000, "response code");
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] x);
      logic [31:0] d;
      rd(a, d);
      chk(d[15:0], x, "register value");
   endtask

   // instruction issue, then room for the dummy cycle
   task automatic exec(input logic [7:0] op, input logic [15:0] arg);
      wr(alu_exec_pkg::OFF_INSTR, {8'h00, op, arg});
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic load(input logic [7:0] a, m, s);
      wr(alu_exec_pkg::OFF_ACC, {24'h000000, a});
      wr(alu_exec_pkg::OFF_MEM, {24'h000000, m});
      wr(alu_exec_pkg::OFF_STATUS, {24'h000000, s});
   endtask

   // reference results: {acc, mem, excess, zero, half, carry}
   function automatic logic [19:0] model(input logic [7:0] op, a, m, x,
                                         input logic [3:0] f);
      logic c, h, z, v, zr;
      logic [8:0] d;
      logic [4:0] l;
      logic [7:0] r;
      {v, z, h, c} = f;
      zr = 1'b1;
      r = 8'h00;
      case (op)
         8'h01: begin m = ~m; r = m; end
         8'h02: begin a = ~m; r = a; end
         8'h03: begin
            d = {1'b0, a} + ((a[3:0] > 4'h9 || h) ? 9'h006 : 9'h000)
                + ((a[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
            m = d[7:0];
            c = c | d[8];
            zr = 1'b0;
         end
         8'h04: begin m = m - 8'h01; r = m; end
         8'h05: begin a = m - 8'h01; r = a; end
         8'h06: begin m = m + 8'h01; r = m; end
         8'h07: begin a = m + 8'h01; r = a; end
         8'h0d: begin a = a | m; r = a; end
         8'h0e: begin a = a | x; r = a; end
         8'h0f: begin m = a | m; r = m; end
         8'h1b: begin
            d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
            l = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
            v = (a[7] != m[7]) && (d[7] != a[7]);
            a = d[7:0];
            c = ~d[8];
            h = ~l[4];
            r = a;
         end
         default: begin
            zr = 1'b0;
            case (op)
               8'h0a: a = m;
               8'h0b: a = x;
               8'h0c: m = a;
               8'h13: m = {m[6:0], m[7]};
               8'h14: a = {m[6:0], m[7]};
               8'h15: {c, m} = {m, c};
               8'h16: {c, a} = {m, c};
               8'h17: m = {m[0], m[7:1]};
               8'h18: a = {m[0], m[7:1]};
               8'h19: {m, c} = {c, m};
               8'h1a: {a, c} = {c, m};
               default: ;
            endcase
         end
      endcase
      if (zr) z = (r == 8'h00);
      return {a, m, v, z, h, c};
   endfunction

   // main sequence
   initial begin
      {nrst, hsel, hwrite, irq_req, htrans} = '0;
      haddr = '0;
      hwdata = '0;
      hsize = 3'b010;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (vm[i]) rchk(8'h08 + 8'(i * 4), 16'h0000);
      rchk(alu_exec_pkg::OFF_PC, 16'h0000);
      $display("test reset done");
      for (int op = 0; op < 28; op++) begin
         if (op inside {8, 9, 16, 17, 18}) continue;
         foreach (va[i]) begin
            load(va[i], vm[i], {4'h0, vf[i]});
            exec(8'(op), 16'h005a);
            e = model(8'(op), va[i], vm[i], 8'h5a, vf[i]);
            rchk(alu_exec_pkg::OFF_ACC, {8'h00, e[19:12]});
            rchk(alu_exec_pkg::OFF_MEM, {8'h00, e[11:4]});
            rd(alu_exec_pkg::OFF_STATUS, rdat);
            chk({12'h000, rdat[3:0]}, {12'h000, e[3:0]}, "flags");
         end
      end
      rchk(alu_exec_pkg::OFF_PC, 16'h005c);
      $display("test operations done");
      load(8'h00, 8'h00, 8'h0f);
      wr(alu_exec_pkg::OFF_STACK, 32'h0321);
      exec(8'h10, 16'h0000);
      rchk(alu_exec_pkg::OFF_PC, 16'h0321);
      rchk(alu_exec_pkg::OFF_STATUS, 16'h000f);
      exec(8'h11, 16'h0077);
      rchk(alu_exec_pkg::OFF_ACC, 16'h0077);
      rchk(alu_exec_pkg::OFF_PC, 16'h0321);
      exec(8'h12, 16'h0000);
      rchk(alu_exec_pkg::OFF_PC, 16'h0321);
      rchk(alu_exec_pkg::OFF_STATUS, 16'h004f);
      wr(alu_exec_pkg::OFF_STATUS, 32'h0);
      wr(alu_exec_pkg::OFF_STACK, 32'h0100);
      irq_req <= 1'b1;
      repeat (5) @(posedge ref_clk);
      exec(8'h12, 16'h0000);
      irq_req <= 1'b0;
      rchk(alu_exec_pkg::OFF_PC, IRQ_VEC);
      rchk(alu_exec_pkg::OFF_STACK, 16'h0100);
      rchk(alu_exec_pkg::OFF_STATUS, 16'h0000);
      exec(8'h09, 16'h1234);
      rchk(alu_exec_pkg::OFF_PC, 16'h1234);
      exec(8'h1c, 16'h00a5);
      rchk(alu_exec_pkg::OFF_PC, 16'h12a5);
      $display("test flow done");
      load(8'h5c, 8'ha3, 8'h20);
      n = wdc_cnt;
      exec(8'h08, 16'h0000);
      chk({15'h0000, sleep_active}, 16'h0001, "asleep");
      chk(16'(wdc_cnt - n), 16'h0001, "watchdog pulses");
      rd(alu_exec_pkg::OFF_STATUS, rdat);
      chk({14'h0000, rdat[5:4]}, 16'h0001, "sleep flags");
      exec(8'h0b, 16'h0011);
      rchk(alu_exec_pkg::OFF_ACC, 16'h005c);
      rchk(alu_exec_pkg::OFF_MEM, 16'h00a3);
      rchk(alu_exec_pkg::OFF_PC, 16'h12a6);
      wr(alu_exec_pkg::OFF_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, sleep_active}, 16'h0000, "awake");
      exec(8'h0b, 16'h0011);
      rchk(alu_exec_pkg::OFF_ACC, 16'h0011);
      // unmapped place reads zero, write has no effect
      rchk(8'h40, 16'h0000);
      wr(8'h40, 32'hff);
      rchk(alu_exec_pkg::OFF_ACC, 16'h0011);
      $display("test sleep done");
      test_done();
   end
endmodule
`default_nettype wire
